// File: hw/lts_link_training_regs.sv
// register slice: equalizer control, mirrored link configuration and lane feed-forward levels
`timescale 1ns/10ps
module lts_link_training_regs (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_link,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic snoop_valid,
    input wire logic snoop_acked,
    input wire logic [7:0] snoop_offset,
    input wire logic [7:0] snoop_data,
    output logic snoop_ready,
    input wire logic [3:0] adapted_eq,
    input wire logic full_adapt_mode,
    input wire logic adapt_done,
    output logic adapt_hit_count_select,
    output logic adapt_equalizer_enable,
    output logic [3:0] eq_setting,
    output logic [3:0] optimal_eq_result,
    output logic bit_to_clock_ratio,
    output logic [3:0] max_feedforward_level,
    output logic [3:0] fixed_link_rate_select,
    output logic fixed_link_enable,
    output logic fixed_link_four_lanes,
    output logic training_no_timeout,
    output logic feedforward_bypass_test,
    output logic deemphasis_only_test,
    output logic preshoot_only_test,
    output logic [3:0] lane0_pattern_request,
    output logic [3:0] lane1_pattern_request,
    output logic [3:0] lane2_pattern_request,
    output logic [3:0] lane3_pattern_request,
    output logic [1:0] ffe_level_lane0,
    output logic [1:0] ffe_level_lane1,
    output logic [1:0] ffe_level_lane2,
    output logic [1:0] ffe_level_lane3
);
    // pattern request register that carries a given lane
    function automatic logic lane_reg_hit(input logic [7:0] ofs, input int lane);
        logic [7:0] want;
        want = (lane < 2) ? lts_pkg::OFS_LANE01 : lts_pkg::OFS_LANE23;
        return ofs == want;
    endfunction : lane_reg_hit

    logic evt_valid, evt_take;
    logic [7:0] evt_offset, evt_data;
    logic [7:0] adapt_ctrl_ff, nxt_adapt_ctrl;
    logic [7:0] clk_ratio_ff, nxt_clk_ratio;
    logic [7:0] link_cfg_ff, nxt_link_cfg;
    logic [7:0] src_test_ff, nxt_src_test;
    logic [7:0] lane01_ff, nxt_lane01;
    logic [7:0] lane23_ff, nxt_lane23;
    logic [7:0] rdata_ff, nxt_rdata;
    logic rvalid_ff;
    logic [3:0] eq_setting_ff, nxt_eq_setting;
    logic [3:0] optimal_ff, nxt_optimal;
    logic [1:0] ffe_level_ff [4];
    logic [1:0] nxt_ffe_level [4];
    logic [3:0] lane_step;
    logic [3:0] lane_clear;

    lts_snoop_cdc u_snoop_cdc (
        .clk_link(clk_link),
        .clk_sys(clk_sys),
        .rst(rst),
        .snoop_valid(snoop_valid),
        .snoop_acked(snoop_acked),
        .snoop_offset(snoop_offset),
        .snoop_data(snoop_data),
        .snoop_ready(snoop_ready),
        .evt_valid(evt_valid),
        .evt_offset(evt_offset),
        .evt_data(evt_data),
        .evt_take(evt_take)
    );

    // one update path: a local write wins the cycle, a snooped event waits for the first cycle without a local write
    assign evt_take = evt_valid && !reg_wr;
    wire upd_en = reg_wr || evt_take;
    wire [7:0] upd_ofs = reg_wr ? reg_addr : evt_offset;
    wire [7:0] upd_dat = reg_wr ? reg_wdata : evt_data;

    wire hit_adapt = reg_wr && (reg_addr == lts_pkg::OFS_ADAPT_CTRL);
    wire hit_ratio = upd_en && (upd_ofs == lts_pkg::OFS_CLK_RATIO); // R6 R21
    wire hit_link = upd_en && (upd_ofs == lts_pkg::OFS_LINK_CFG); // R21
    wire hit_test = upd_en && (upd_ofs == lts_pkg::OFS_SRC_TEST); // R21
    wire hit_l01 = upd_en && (upd_ofs == lts_pkg::OFS_LANE01); // R21
    wire hit_l23 = upd_en && (upd_ofs == lts_pkg::OFS_LANE23); // R19 R21

    assign nxt_adapt_ctrl = hit_adapt ? reg_wdata : adapt_ctrl_ff;
    assign nxt_clk_ratio = hit_ratio ? (upd_dat & lts_pkg::MASK_CLK_RATIO) : clk_ratio_ff; // R7
    assign nxt_link_cfg = hit_link ? upd_dat : link_cfg_ff; // R7 R8 R9
    assign nxt_src_test = hit_test ? (upd_dat & lts_pkg::MASK_SRC_TEST) : src_test_ff; // R7
    assign nxt_lane01 = hit_l01 ? upd_dat : lane01_ff; // R14 R15
    assign nxt_lane23 = hit_l23 ? upd_dat : lane23_ff; // R19

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            adapt_ctrl_ff <= lts_pkg::RST_BYTE; // R22
            clk_ratio_ff <= lts_pkg::RST_BYTE;
            link_cfg_ff <= lts_pkg::RST_BYTE;
            src_test_ff <= lts_pkg::RST_BYTE;
            lane01_ff <= lts_pkg::RST_BYTE;
            lane23_ff <= lts_pkg::RST_BYTE;
        end else begin
            adapt_ctrl_ff <= nxt_adapt_ctrl;
            clk_ratio_ff <= nxt_clk_ratio;
            link_cfg_ff <= nxt_link_cfg;
            src_test_ff <= nxt_src_test;
            lane01_ff <= nxt_lane01;
            lane23_ff <= nxt_lane23;
        end
    end

    // equalizer control fields
    assign adapt_hit_count_select = adapt_ctrl_ff[lts_pkg::BIT_HIT_SEL]; // R1
    assign adapt_equalizer_enable = adapt_ctrl_ff[lts_pkg::BIT_ADAPT_EN]; // R2
    wire ofs_negative = adapt_ctrl_ff[lts_pkg::BIT_OFS_SIGN]; // R3
    wire [2:0] ofs_magnitude = adapt_ctrl_ff[2:0];

    // signed offset: n, or n - 8 when negative
    wire signed [5:0] ofs_signed = ofs_negative ? ($signed({3'b000, ofs_magnitude}) - 6'sd8)
                                                : $signed({3'b000, ofs_magnitude}); // R4
    wire signed [5:0] eq_sum = $signed({2'b00, adapted_eq}) + ofs_signed;
    wire [3:0] eq_clamped = (eq_sum < 6'sd0) ? 4'h0
                          : (eq_sum > $signed(lts_pkg::EQ_MAX)) ? 4'hf : eq_sum[3:0]; // R20

    assign nxt_eq_setting = full_adapt_mode ? eq_clamped : adapted_eq; // R5
    assign nxt_optimal = adapt_done ? eq_clamped : optimal_ff; // R18

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            eq_setting_ff <= 4'h0;
            optimal_ff <= 4'h0;
        end else begin
            eq_setting_ff <= nxt_eq_setting;
            optimal_ff <= nxt_optimal;
        end
    end

    assign eq_setting = eq_setting_ff;
    assign optimal_eq_result = optimal_ff;

    // mirrored configuration fields
    assign bit_to_clock_ratio = clk_ratio_ff[lts_pkg::BIT_CLK_RATIO]; // R6
    assign max_feedforward_level = link_cfg_ff[7:4]; // R8
    assign fixed_link_rate_select = link_cfg_ff[3:0]; // R9
    assign fixed_link_enable = (link_cfg_ff[3:0] != 4'h0) && (link_cfg_ff[3:0] <= lts_pkg::RATE_LAST); // R9
    assign fixed_link_four_lanes = fixed_link_enable && (link_cfg_ff[3:0] >= lts_pkg::RATE_FIRST_4LANE); // R9
    assign training_no_timeout = src_test_ff[lts_pkg::BIT_NO_TIMEOUT]; // R10
    assign feedforward_bypass_test = src_test_ff[lts_pkg::BIT_FFE_BYPASS]; // R11
    assign deemphasis_only_test = src_test_ff[lts_pkg::BIT_DEEMPH]; // R12
    assign preshoot_only_test = src_test_ff[lts_pkg::BIT_PRESHOOT]; // R13
    assign lane0_pattern_request = lane01_ff[3:0]; // R15
    assign lane1_pattern_request = lane01_ff[7:4]; // R14
    assign lane2_pattern_request = lane23_ff[3:0]; // R19
    assign lane3_pattern_request = lane23_ff[7:4]; // R19

    // levels above the top code are capped at the top supported level
    wire [1:0] ffe_cap = (link_cfg_ff[7:4] > {2'b00, lts_pkg::FFE_TOP}) ? lts_pkg::FFE_TOP
                                                                       : link_cfg_ff[5:4];
    wire clear_all = |lane_clear; // R17

    genvar gl;
    generate
        for (gl = 0; gl < 4; gl++) begin : g_lane
            wire [3:0] req = upd_dat[4 * (gl % 2) +: 4];
            wire hit = upd_en && lane_reg_hit(upd_ofs, gl);
            assign lane_step[gl] = hit && (req == lts_pkg::PAT_STEP); // R16 R19
            assign lane_clear[gl] = hit && (req == lts_pkg::PAT_CLEAR); // R17 R19
            assign nxt_ffe_level[gl] = clear_all ? 2'h0
                                     : (lane_step[gl] && (ffe_level_ff[gl] < ffe_cap))
                                       ? ffe_level_ff[gl] + 2'h1 : ffe_level_ff[gl]; // R16
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    ffe_level_ff[gl] <= 2'h0;
                end else begin
                    ffe_level_ff[gl] <= nxt_ffe_level[gl];
                end
            end
        end
    endgenerate

    assign ffe_level_lane0 = ffe_level_ff[0];
    assign ffe_level_lane1 = ffe_level_ff[1];
    assign ffe_level_lane2 = ffe_level_ff[2];
    assign ffe_level_lane3 = ffe_level_ff[3];

    // local read port, answer registered one cycle after the strobe
    assign nxt_rdata = (reg_addr == lts_pkg::OFS_ADAPT_CTRL) ? adapt_ctrl_ff
                     : (reg_addr == lts_pkg::OFS_CLK_RATIO) ? clk_ratio_ff
                     : (reg_addr == lts_pkg::OFS_LINK_CFG) ? link_cfg_ff
                     : (reg_addr == lts_pkg::OFS_SRC_TEST) ? src_test_ff
                     : (reg_addr == lts_pkg::OFS_LANE01) ? lane01_ff
                     : (reg_addr == lts_pkg::OFS_LANE23) ? lane23_ff
                     : lts_pkg::RST_BYTE;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_ff <= lts_pkg::RST_BYTE;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= reg_rd;
            if (reg_rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign reg_rdata = rdata_ff;
    assign reg_rvalid = rvalid_ff;
endmodule : lts_link_training_regs

// File: hw/lts_pkg.sv
// constants for the link training snoop register slice
// How it works
// R1 - adaptation mode bit 7: 0 counts mid-eye hits every setting, 1 only at setting zero
// R2 - adaptive equalization runs only while enable bit 6 is one
// R3 - bit 3 is offset sign: 0 adds, 1 subtracts
// R4 - offset code n adds n, or n minus 8 when sign is negative
// R5 - offset applies only in full adaptive mode, ignored otherwise; optimal_eq_result takes it on adapt_done in either mode
// R6 - clock-ratio bit 1: 0 means one tenth, 1 means one fortieth; snoop or local write
// R7 - mirrored fields return last snooped or locally written value, whichever came last
// R8 - bits 7-4 hold highest feed-forward level allowed at current link rate
// R9 - bits 3-0 decode fixed link rate and lane count; 0 disables
// R10 - bit 5 mirrors the no-timeout flag for link training
// R11 - source-test bit 3 mirrors feed-forward bypass test mode
// R12 - source-test bit 2 mirrors de-emphasis-only test mode
// R13 - source-test bit 1 mirrors pre-shoot-only test mode
// R14 - lane 1 pattern request held in bits 7-4, last seen value
// R15 - lane 0 pattern request held in bits 3-0, last seen value
// R16 - request Eh steps that lane's feed-forward level, saturating at the maximum
// R17 - request Fh on any lane clears all lanes' feed-forward levels
// R18 - reported optimal equalizer result includes the signed offset
// R19 - lanes 3 and 2 requests live in a second register, same behaviour
// R20 - offset-adjusted setting clamps to 0..15, never wraps
// R21 - snooped transactions update mirrors only when acknowledged and at matching offsets
// R22 - every field clears to zero on reset
package lts_pkg;
    localparam logic [7:0] OFS_ADAPT_CTRL = 8'h1e;
    localparam logic [7:0] OFS_CLK_RATIO = 8'h20;
    localparam logic [7:0] OFS_LINK_CFG = 8'h31;
    localparam logic [7:0] OFS_SRC_TEST = 8'h35;
    localparam logic [7:0] OFS_LANE01 = 8'h41;
    localparam logic [7:0] OFS_LANE23 = 8'h42;
    localparam int BIT_HIT_SEL = 7;
    localparam int BIT_ADAPT_EN = 6;
    localparam int BIT_OFS_SIGN = 3;
    localparam int BIT_CLK_RATIO = 1;
    localparam int BIT_NO_TIMEOUT = 5;
    localparam int BIT_FFE_BYPASS = 3;
    localparam int BIT_DEEMPH = 2;
    localparam int BIT_PRESHOOT = 1;
    localparam logic [7:0] MASK_CLK_RATIO = 8'h02;
    localparam logic [7:0] MASK_SRC_TEST = 8'h2e;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] PAT_STEP = 4'he;
    localparam logic [3:0] PAT_CLEAR = 4'hf;
    localparam logic [1:0] FFE_TOP = 2'h3;
    localparam logic [3:0] RATE_LAST = 4'h6;
    localparam logic [3:0] RATE_FIRST_4LANE = 4'h3;
    localparam logic [5:0] EQ_MAX = 6'h0f;
endpackage : lts_pkg

// File: hw/lts_snoop_cdc.sv
// carries acknowledged display-channel transactions from the link clock into clk_sys
`timescale 1ns/10ps
module lts_snoop_cdc (
    input wire logic clk_link,
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic snoop_valid,
    input wire logic snoop_acked,
    input wire logic [7:0] snoop_offset,
    input wire logic [7:0] snoop_data,
    output logic snoop_ready,
    output logic evt_valid,
    output logic [7:0] evt_offset,
    output logic [7:0] evt_data,
    input wire logic evt_take
);
    logic rst_l1_ff, rst_l2_ff;
    logic busy_ff, req_tgl_ff;
    logic ack_s1_ff, ack_s2_ff;
    logic [7:0] ofs_ff, dat_ff;
    logic req_s1_ff, req_s2_ff, req_s3_ff, ack_tgl_ff;
    wire capture = snoop_valid && snoop_acked && !busy_ff; // R21
    wire nxt_busy = capture || (busy_ff && (ack_s2_ff != req_tgl_ff));

    // link side: reset is brought over so the capture flops start clean
    always_ff @(posedge clk_link) begin
        rst_l1_ff <= rst;
        rst_l2_ff <= rst_l1_ff;
    end

    always_ff @(posedge clk_link) begin
        ack_s1_ff <= ack_tgl_ff;
        ack_s2_ff <= ack_s1_ff;
        if (rst_l2_ff) begin
            busy_ff <= 1'b0;
            req_tgl_ff <= 1'b0;
            ofs_ff <= lts_pkg::RST_BYTE;
            dat_ff <= lts_pkg::RST_BYTE;
        end else begin
            busy_ff <= nxt_busy;
            if (capture) begin
                req_tgl_ff <= ~req_tgl_ff;
                ofs_ff <= snoop_offset;
                dat_ff <= snoop_data;
            end
        end
    end

    assign snoop_ready = !busy_ff;

    // system side: offset and data are stable while the toggle travels
    always_ff @(posedge clk_sys) begin
        req_s1_ff <= req_tgl_ff;
        req_s2_ff <= req_s1_ff;
        req_s3_ff <= req_s2_ff;
        if (rst) begin
            ack_tgl_ff <= 1'b0;
        end else if (evt_take) begin
            ack_tgl_ff <= ~ack_tgl_ff;
        end
    end

    assign evt_valid = (req_s2_ff == req_s3_ff) && (req_s3_ff != ack_tgl_ff);
    assign evt_offset = ofs_ff;
    assign evt_data = dat_ff;
endmodule : lts_snoop_cdc

// File: verification/lts_link_training_regs_tb.sv
// self-checking bench for the link training register slice
`timescale 1ns/10ps
module lts_link_training_regs_tb;
    logic clk_sys = 1'b0, rst, clk_link, reg_wr, reg_rd, reg_rvalid, full_adapt_mode, adapt_done;
    logic snoop_valid, snoop_acked, snoop_ready, adapt_hit_count_select, adapt_equalizer_enable;
    logic bit_to_clock_ratio, fixed_link_enable, fixed_link_four_lanes, training_no_timeout;
    logic feedforward_bypass_test, deemphasis_only_test, preshoot_only_test;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, snoop_offset, snoop_data;
    logic [3:0] adapted_eq, eq_setting, optimal_eq_result, max_feedforward_level, fixed_link_rate_select;
    logic [3:0] lane0_pattern_request, lane1_pattern_request, lane2_pattern_request, lane3_pattern_request;
    logic [1:0] ffe_level_lane0, ffe_level_lane1, ffe_level_lane2, ffe_level_lane3;
    logic [7:0] expq[$];
    logic [31:0] seed = 32'h246b8145;
    int miscompares = 0, num_checks = 0, cyc = 0;
    logic [7:0] ofs [6] = '{8'h1e, 8'h20, 8'h31, 8'h35, 8'h41, 8'h42};
    logic [7:0] msk [6] = '{8'hff, 8'h02, 8'hff, 8'h2e, 8'hff, 8'hff};
    logic [7:0] eqc [6] = '{8'h02, 8'h07, 8'h0a, 8'h0f, 8'h08, 8'h07};
    logic [4:0] eqa [6] = '{5'h16, 5'h1c, 5'h13, 5'h19, 5'h1f, 5'h05};
    logic [7:0] eqe [6] = '{8'h08, 8'h0f, 8'h00, 8'h08, 8'h07, 8'h05};
    logic [7:0] wv [6];
    lts_link_training_regs dut_u (.*);
    lts_snoop_source src_u (.*);
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        @(negedge clk_sys);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge clk_sys);
        reg_rd = 1'b0;
    endtask : rd
    task automatic snoop(input logic [7:0] o, input logic [7:0] d, input logic ack);
        src_u.send(o, d, ack);
        repeat (6) @(negedge clk_sys);
    endtask : snoop
    task automatic reset_dut();
        rst = 1'b1;
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
    endtask : reset_dut
    task automatic report_and_stop();
        $display("num_checks=%0d miscompares=%0d pending=%0d", num_checks, miscompares, expq.size());
        if (miscompares == 0 && num_checks > 0 && expq.size() == 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    // read answers are compared against the oldest note in the queue
    always @(negedge clk_sys) if (reg_rvalid === 1'b1) chk(reg_rdata, expq.pop_front());
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        {reg_wr, reg_rd, full_adapt_mode, adapt_done, adapted_eq, reg_addr, reg_wdata} = 24'h0;
        reset_dut();
        for (int i = 0; i < 6; i++) rd(ofs[i], 8'h00);
        for (int i = 0; i < 6; i++) begin
            wv[i] = 8'(xs());
            wr(ofs[i], wv[i]);
            rd(ofs[i], wv[i] & msk[i]);
        end
        chk({6'h00, adapt_hit_count_select, adapt_equalizer_enable}, {6'h00, wv[0][7:6]});
        chk({7'h00, bit_to_clock_ratio}, {7'h00, wv[1][1]});
        chk({max_feedforward_level, fixed_link_rate_select}, wv[2]);
        chk({4'h0, training_no_timeout, feedforward_bypass_test, deemphasis_only_test, preshoot_only_test},
            {4'h0, wv[3][5], wv[3][3:1]});
        chk({lane1_pattern_request, lane0_pattern_request}, wv[4]);
        chk({lane3_pattern_request, lane2_pattern_request}, wv[5]);
        wr(8'h55, 8'hff);
        rd(8'h55, 8'h00);
        for (int c = 0; c < 16; c++) begin
            wr(8'h31, {4'h3, 4'(c)});
            chk({6'h00, fixed_link_enable, fixed_link_four_lanes}, {6'h00, c >= 1 && c <= 6, c >= 3 && c <= 6});
        end
        wr(8'h31, 8'h20);
        wr(8'h41, 8'hff);
        for (int i = 0; i < 3; i++) begin
            wr(8'h41, 8'he0);
            chk({4'h0, ffe_level_lane1, ffe_level_lane0}, {4'h0, i < 1 ? 2'h1 : 2'h2, 2'h0});
        end
        wr(8'h42, 8'hee);
        chk({4'h0, ffe_level_lane3, ffe_level_lane2}, 8'h05);
        wr(8'h42, 8'hf0);
        chk({ffe_level_lane3, ffe_level_lane2, ffe_level_lane1, ffe_level_lane0}, 8'h00);
        snoop(8'h41, 8'h0e, 1'b1);
        chk({4'h0, ffe_level_lane1, ffe_level_lane0}, 8'h01);
        wr(8'h41, 8'hef);
        chk({ffe_level_lane3, ffe_level_lane2, ffe_level_lane1, ffe_level_lane0}, 8'h00);
        snoop(8'h31, 8'h32, 1'b1);
        chk({7'h00, snoop_ready}, 8'h01);
        rd(8'h31, 8'h32);
        wr(8'h20, 8'h00);
        snoop(8'h20, 8'h02, 1'b0);
        rd(8'h20, 8'h00);
        snoop(8'h1e, 8'h00, 1'b1);
        rd(8'h1e, wv[0]);
        snoop(8'h20, 8'h02, 1'b1);
        rd(8'h20, 8'h02);
        wr(8'h20, 8'h00);
        rd(8'h20, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(8'h1e, eqc[i]);
            {full_adapt_mode, adapted_eq} = eqa[i];
            adapt_done = eqa[i][4];
            @(negedge clk_sys);
            adapt_done = 1'b0;
            chk({4'h0, eq_setting}, eqe[i]);
            if (eqa[i][4]) chk({4'h0, optimal_eq_result}, eqe[i]);
        end
        reset_dut();
        for (int i = 0; i < 6; i++) rd(ofs[i], 8'h00);
        chk({ffe_level_lane3, ffe_level_lane2, ffe_level_lane1, ffe_level_lane0}, 8'h00);
        repeat (2) @(negedge clk_sys);
        report_and_stop();
    end
endmodule : lts_link_training_regs_tb
bind lts_link_training_regs lts_regs_sva chk_u (.*);

// File: verification/lts_regs_sva.sv
// port checker for the link training register slice
`timescale 1ns/10ps
module lts_regs_sva (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [3:0] adapted_eq,
    input wire logic full_adapt_mode,
    input wire logic adapt_equalizer_enable,
    input wire logic [3:0] eq_setting,
    input wire logic bit_to_clock_ratio,
    input wire logic [3:0] max_feedforward_level,
    input wire logic [3:0] fixed_link_rate_select,
    input wire logic fixed_link_enable,
    input wire logic fixed_link_four_lanes,
    input wire logic [3:0] lane0_pattern_request,
    input wire logic [1:0] ffe_level_lane0,
    input wire logic [1:0] ffe_level_lane1,
    input wire logic [1:0] ffe_level_lane2,
    input wire logic [1:0] ffe_level_lane3
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_rv; reg_rd |=> reg_rvalid; endproperty
    a_rv: assert property (p_rv) else $error("read answer missing");
    property p_ratio; reg_rd && reg_addr == lts_pkg::OFS_CLK_RATIO |=>
        reg_rdata == {6'h00, $past(bit_to_clock_ratio), 1'b0}; endproperty
    a_ratio: assert property (p_ratio) else $error("ratio read wrong");
    property p_rate; reg_rd && reg_addr == lts_pkg::OFS_LINK_CFG |=>
        reg_rdata == {$past(max_feedforward_level), $past(fixed_link_rate_select)}; endproperty
    a_rate: assert property (p_rate) else $error("link config read wrong");
    property p_en; fixed_link_enable == (fixed_link_rate_select inside {[4'h1:4'h6]}); endproperty
    a_en: assert property (p_en) else $error("link enable decode wrong");
    property p_four; fixed_link_four_lanes == (fixed_link_rate_select inside {[4'h3:4'h6]}); endproperty
    a_four: assert property (p_four) else $error("lane count decode wrong");
    property p_eq; !full_adapt_mode |=> eq_setting == $past(adapted_eq); endproperty
    a_eq: assert property (p_eq) else $error("offset used outside full mode");
    property p_aen; !(reg_wr && reg_addr == lts_pkg::OFS_ADAPT_CTRL) |=> $stable(adapt_equalizer_enable); endproperty
    a_aen: assert property (p_aen) else $error("enable changed without write");
    property p_step; ffe_level_lane1 > $past(ffe_level_lane1) |->
        ffe_level_lane1 == $past(ffe_level_lane1) + 2'h1 && {2'h0, ffe_level_lane1} <= max_feedforward_level;
    endproperty
    a_step: assert property (p_step) else $error("level step wrong");
    property p_clr; ffe_level_lane1 < $past(ffe_level_lane1) |->
        {ffe_level_lane0, ffe_level_lane1, ffe_level_lane2, ffe_level_lane3} == 8'h00; endproperty
    a_clr: assert property (p_clr) else $error("partial level clear");
    property p_pat; $changed(lane0_pattern_request) && lane0_pattern_request == lts_pkg::PAT_CLEAR |->
        {ffe_level_lane0, ffe_level_lane1, ffe_level_lane2, ffe_level_lane3} == 8'h00; endproperty
    a_pat: assert property (p_pat) else $error("clear request kept levels");
    c_rd: cover property (reg_rvalid);
    c_sat: cover property (ffe_level_lane1 == 2'h2 && max_feedforward_level == 4'h2);
    c_four: cover property (fixed_link_four_lanes);
endmodule : lts_regs_sva

// File: verification/lts_snoop_source.sv
// display-channel source model presenting snooped transfers on the link clock
`timescale 1ns/10ps
module lts_snoop_source (
    input wire logic rst,
    input wire logic snoop_ready,
    output logic clk_link,
    output logic snoop_valid,
    output logic snoop_acked,
    output logic [7:0] snoop_offset,
    output logic [7:0] snoop_data
);
    logic busy = 1'b0;
    // clock runs through reset and each transfer, stands low in between
    initial begin
        {clk_link, snoop_valid, snoop_acked, snoop_offset, snoop_data} = 19'h0;
        #3.3;
        forever #6 if (rst || busy || clk_link) clk_link = ~clk_link;
    end
    task automatic send(input logic [7:0] o, input logic [7:0] d, input logic ack);
        int n;
        busy = 1'b1;
        n = 0;
        // drive and release on the falling edge, away from the capturing rising edge
        repeat (4) @(negedge clk_link);
        while (snoop_ready !== 1'b1 && n < 40) begin
            @(negedge clk_link);
            n++;
        end
        {snoop_valid, snoop_acked, snoop_offset, snoop_data} = {1'b1, ack, o, d};
        @(negedge clk_link);
        // released lines show the inverse of the last value
        {snoop_valid, snoop_acked, snoop_offset, snoop_data} = {1'b0, ~ack, ~o, ~d};
        // clock keeps running until the ready return has crossed back
        repeat (16) @(negedge clk_link);
        busy = 1'b0;
    endtask : send
endmodule : lts_snoop_source
